// file: common/fwc_pkg.sv
// Shared constants for the four-way cache controller and its CPU-side requester.
// Assumes a 32-bit cache bus with big-endian byte lanes and 16-byte lines.
package fwc_pkg;
    // Geometry.
    localparam int WAYS       = 4;
    localparam int ENTRIES    = 64;
    localparam int LINE_WORDS = 4;
    localparam int TAG_W      = 19;
    localparam int LRU_W      = 6;

    // Address fields.
    localparam int WORD_LO = 2;
    localparam int WORD_HI = 3;
    localparam int IDX_LO  = 4;
    localparam int IDX_HI  = 9;
    localparam int TAG_LO  = 10;
    localparam int TAG_HI  = 28;
    localparam int AREA_LO = 29;
    localparam int DWAY_LO = 10;
    localparam int DWAY_HI = 11;

    // Address partitions on the top three address bits.
    localparam logic [2:0] AREA_CACHE   = 3'h0;
    localparam logic [2:0] AREA_THRU    = 3'h1;
    localparam logic [2:0] AREA_PURGE   = 3'h2;
    localparam logic [2:0] AREA_ADDRARR = 3'h3;
    localparam logic [2:0] AREA_DATAARR = 3'h6;
    localparam logic [2:0] AREA_IO      = 3'h7;

    // Windows and the purge offset.
    localparam logic [31:0] PURGE_OFFSET  = 32'h40000000;
    localparam logic [31:0] DATA_WIN_BASE = 32'hC0000000;
    localparam logic [31:0] DATA_WIN_MASK = 32'h00000FFF;
    localparam logic [31:0] DATA_WIN_TOP  = DATA_WIN_BASE | DATA_WIN_MASK;
    localparam logic [31:0] RAM_HALF_TOP  = DATA_WIN_BASE | 32'h000007FF;
    localparam logic [31:0] ADDR_WIN_BASE = 32'h60000000;
    localparam logic [31:0] ADDR_WIN_MASK = 32'h000003FF;
    localparam logic [31:0] ADDR_WIN_TOP  = ADDR_WIN_BASE | ADDR_WIN_MASK;
    localparam logic [31:0] CTRL_ADDR     = 32'hFFFFFE00;

    // Control register bits.
    localparam int         CTL_WAY_HI = 7;
    localparam int         CTL_WAY_LO = 6;
    localparam int         CTL_PURGE  = 4;
    localparam int         CTL_TWOWAY = 3;
    localparam int         CTL_DINH   = 2;
    localparam int         CTL_IINH   = 1;
    localparam int         CTL_EN     = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CTRL_WMASK = 8'hCF;

    // Address array data layout.
    localparam int AA_VALID_BIT = 2;
    localparam int AA_LRU_LO    = 4;
    localparam int AA_LRU_HI    = 9;

    // Access sizes.
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_WORD = 2'h1;
    localparam logic [1:0] SZ_LONG = 2'h2;

    // Bit that an atomic write-back forces high in its byte.
    localparam int TAS_SET_BIT = 7;

    // Usage order bits: per way the bits touched, the update value and the victim pattern.
    localparam logic [3:0][5:0] LRU_MASK  = {6'h0B, 6'h15, 6'h26, 6'h38};
    localparam logic [3:0][5:0] LRU_UPD   = {6'h0B, 6'h14, 6'h20, 6'h00};
    localparam logic [3:0][5:0] LRU_VIC   = {6'h00, 6'h01, 6'h06, 6'h38};
    localparam int              LRU_PAIR  = 0;
endpackage

// file: common/fwc_if.sv
// Cache bus between the CPU-side requester and the cache controller.
// Assumes both ends run on the same clock; the bench supplies nothing but wires.
`timescale 1ns/1ps
interface fwc_if;
    logic        req;
    logic        wr;
    logic        instr;
    logic        atomic;
    logic [1:0]  size;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        ack;
    logic [31:0] rdata;

    modport dev (input req, wr, instr, atomic, size, addr, wdata, output ack, rdata);
    modport cpu (output req, wr, instr, atomic, size, addr, wdata, input ack, rdata);
endinterface

// file: logic/fwc_cache.sv
// Four-way write-through cache controller between the cache bus and the internal bus.
// Assumes the requester waits for ack before a new request and the internal bus
// answers on the same clock.
// What this block does
// RQ1: Through reads fetch one item, no fill.
// RQ2: Through writes go out, no compare; cached writes compare, update hit, no fill.
// RQ3: Atomic read phase is through, no compare.
// RQ4: Atomic write: compare, update hit, set top bit.
// RQ5: Allowed read miss fills 16-byte line into victim.
// RQ6: Six order bits updated on hits and fills.
// RQ7: Order bit update per accessed way.
// RQ8: Victim way chosen from order bits.
// RQ9: Zeroed order bits fill way 3 first.
// RQ10: Inhibited miss fetches straight to CPU.
// RQ11: Two-way mode replaces ways 2, 3 only.
// RQ12: Tag and valid written before fill ends.
// RQ13: Purge-all clears valid, order in one cycle.
// RQ14: Reset clears enable, leaves arrays untouched.
// RQ15: Software disables cache before purging it.
// RQ16: Purge-area write invalidates matching line only.
// RQ17: Line purge takes two cycles, longword writes.
// RQ18: Data array access one cycle, any size.
// RQ19: Data window maps each way to 1 kbyte.
// RQ20: Data window usable as on-chip RAM.
// RQ21: Address array window, way from control, longword.
// RQ22: Address array read and write field layout.
// RQ23: Invalid entries never hit.
`timescale 1ns/1ps
module fwc_cache (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        rstn,
    // Cache bus from the CPU.
    fwc_if.dev               bus,
    // Internal bus toward memory.
    output logic             ibReq,
    output logic             ibWr,
    output logic [1:0]       ibSize,
    output logic [31:0]      ibAddr,
    output logic [31:0]      ibWdata,
    input  wire logic        ibAck,
    input  wire logic [31:0] ibRdata,
    // Status.
    output logic             cacheEnabled
);
    typedef enum logic [2:0] {ST_IDLE, ST_THRU, ST_WRITE, ST_FILL, ST_PURGE} fwc_state_e;

    fwc_state_e  state;
    logic [7:0]  ctrl;
    logic [31:0] rAddr;
    logic [3:0]  rHit;
    logic [1:0]  fillWord;
    logic [1:0]  fillCnt;
    logic [1:0]  fillWay;

    logic [fwc_pkg::TAG_W-1:0] tagArr   [fwc_pkg::WAYS][fwc_pkg::ENTRIES];
    logic                      validArr [fwc_pkg::WAYS][fwc_pkg::ENTRIES];
    logic [fwc_pkg::LRU_W-1:0] lruArr   [fwc_pkg::ENTRIES];
    logic [31:0]               dataArr  [fwc_pkg::WAYS*fwc_pkg::ENTRIES*fwc_pkg::LINE_WORDS];

    // Request decode, valid only while a request is presented in idle.
    logic [2:0]                area;
    logic [5:0]                idx;
    logic [fwc_pkg::TAG_W-1:0] tag;
    logic [3:0]                hitVec;
    logic                      hitAny;
    logic [1:0]                hitWay;
    logic [1:0]                victim;
    logic [5:0]                lruNow;
    logic                      take;
    logic                      isCtrl;
    logic                      isData;
    logic                      isAddr;
    logic                      cacheOn;
    logic                      inhibit;
    logic                      rdHit;
    logic                      doFill;
    logic                      wrHit;
    logic                      aaWrite;
    logic                      dataWrite;
    logic [3:0]                byteEn;
    logic [9:0]                wordIdx;
    logic [31:0]               aaData;
    logic [31:0]               next_wdata;
    logic [1:0]                aaWay;

    function automatic logic [5:0] lruUpdate(input logic [5:0] l, input logic [1:0] w);
        lruUpdate = (l & ~fwc_pkg::LRU_MASK[w]) | fwc_pkg::LRU_UPD[w]; // RQ7
    endfunction

    // The table patterns cannot all miss once software keeps the bits sane; way 3 is the fallback.
    function automatic logic [1:0] pickVictim(input logic [5:0] l, input logic two);
        pickVictim = 2'h3;
        if (two) begin
            pickVictim = l[fwc_pkg::LRU_PAIR] ? 2'h2 : 2'h3; // RQ11
        end else begin
            for (int w = fwc_pkg::WAYS - 1; w >= 0; w--) begin
                if ((l & fwc_pkg::LRU_MASK[w]) == fwc_pkg::LRU_VIC[w]) begin
                    pickVictim = 2'(w); // RQ8 RQ9
                end
            end
        end
    endfunction

    // Tag compare and access classification.
    always_comb begin
        area    = bus.addr[31:fwc_pkg::AREA_LO];
        idx     = bus.addr[fwc_pkg::IDX_HI:fwc_pkg::IDX_LO];
        tag     = bus.addr[fwc_pkg::TAG_HI:fwc_pkg::TAG_LO];
        lruNow  = lruArr[idx];
        aaWay   = ctrl[fwc_pkg::CTL_WAY_HI:fwc_pkg::CTL_WAY_LO]; // RQ21
        hitAny  = 1'b0;
        hitWay  = 2'h0;
        for (int w = fwc_pkg::WAYS - 1; w >= 0; w--) begin
            hitVec[w] = validArr[w][idx] && (tagArr[w][idx] == tag); // RQ23
            if (hitVec[w]) begin
                hitAny = 1'b1;
                hitWay = 2'(w);
            end
        end
        victim  = pickVictim(lruNow, ctrl[fwc_pkg::CTL_TWOWAY]);
        take    = (state == ST_IDLE) && bus.req;
        isCtrl  = bus.addr == fwc_pkg::CTRL_ADDR;
        isData  = (bus.addr & ~fwc_pkg::DATA_WIN_MASK) == fwc_pkg::DATA_WIN_BASE;
        isAddr  = (bus.addr & ~fwc_pkg::ADDR_WIN_MASK) == fwc_pkg::ADDR_WIN_BASE;
        cacheOn = (area == fwc_pkg::AREA_CACHE) && ctrl[fwc_pkg::CTL_EN];
        inhibit = bus.instr ? ctrl[fwc_pkg::CTL_IINH] : ctrl[fwc_pkg::CTL_DINH];
        rdHit   = take && !bus.wr && cacheOn && !bus.atomic && hitAny; // RQ3
        doFill  = take && !bus.wr && cacheOn && !bus.atomic && !hitAny && !inhibit; // RQ5 RQ10
        wrHit   = take && bus.wr && cacheOn && hitAny && !isCtrl; // RQ2 RQ4
        aaWrite = take && bus.wr && isAddr && (bus.size == fwc_pkg::SZ_LONG); // RQ21
        dataWrite = take && bus.wr && isData; // RQ18 RQ20
        unique case (bus.size)
            fwc_pkg::SZ_BYTE: byteEn = 4'h8 >> bus.addr[1:0];
            fwc_pkg::SZ_WORD: byteEn = bus.addr[1] ? 4'h3 : 4'hC;
            default:          byteEn = 4'hF;
        endcase
        wordIdx = isData ? bus.addr[fwc_pkg::DWAY_HI:fwc_pkg::WORD_LO] // RQ19
                         : {hitWay, idx, bus.addr[fwc_pkg::WORD_HI:fwc_pkg::WORD_LO]};
        aaData  = 32'h0; // RQ22
        aaData[fwc_pkg::TAG_HI:fwc_pkg::TAG_LO]       = tagArr[aaWay][idx];
        aaData[fwc_pkg::AA_LRU_HI:fwc_pkg::AA_LRU_LO] = lruNow;
        aaData[fwc_pkg::AA_VALID_BIT]                 = validArr[aaWay][idx];
        // The atomic write-back forces the top bit of its own byte lane.
        next_wdata = bus.wdata;
        if (bus.atomic) begin
            next_wdata = bus.wdata | ((32'h1 << fwc_pkg::TAS_SET_BIT) << {~bus.addr[1:0], 3'h0}); // RQ4
        end
    end

    // Control register; reset clears enable and every mode bit, the purge bit never stores.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl <= fwc_pkg::CTRL_RESET; // RQ14
        end else if (take && bus.wr && isCtrl) begin
            ctrl <= bus.wdata[7:0] & fwc_pkg::CTRL_WMASK; // RQ13
        end
    end
    assign cacheEnabled = ctrl[fwc_pkg::CTL_EN];

    // Sequencer: answers to the CPU and cycles on the internal bus.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state    <= ST_IDLE;
            bus.ack  <= 1'b0;
            bus.rdata <= 32'h0;
            ibReq    <= 1'b0;
            ibWr     <= 1'b0;
            ibSize   <= fwc_pkg::SZ_LONG;
            ibAddr   <= 32'h0;
            ibWdata  <= 32'h0;
            rAddr    <= 32'h0;
            rHit     <= 4'h0;
            fillWord <= 2'h0;
            fillCnt  <= 2'h0;
            fillWay  <= 2'h0;
        end else begin
            bus.ack <= 1'b0;
            unique case (state)
                ST_IDLE: if (bus.req) begin
                    rAddr <= bus.addr;
                    if (isCtrl && !bus.wr) begin
                        bus.ack   <= 1'b1;
                        bus.rdata <= {24'h0, ctrl}; // RQ13
                    end else if (isCtrl || isData || isAddr) begin
                        bus.ack   <= 1'b1; // RQ18
                        bus.rdata <= isData ? dataArr[wordIdx] :
                                     (bus.size == fwc_pkg::SZ_LONG) ? aaData : 32'h0;
                    end else if (area == fwc_pkg::AREA_PURGE) begin
                        rHit  <= hitVec;
                        state <= ST_PURGE; // RQ17
                    end else if (rdHit) begin
                        bus.ack   <= 1'b1;
                        bus.rdata <= dataArr[wordIdx];
                    end else if (doFill) begin
                        fillWay  <= victim;
                        fillWord <= bus.addr[fwc_pkg::WORD_HI:fwc_pkg::WORD_LO] + 2'h1;
                        fillCnt  <= 2'h0;
                        ibReq    <= 1'b1;
                        ibWr     <= 1'b0;
                        ibSize   <= fwc_pkg::SZ_LONG;
                        ibAddr   <= {bus.addr[31:fwc_pkg::IDX_LO],
                                     bus.addr[fwc_pkg::WORD_HI:fwc_pkg::WORD_LO] + 2'h1, 2'h0};
                        state    <= ST_FILL; // RQ5
                    end else begin
                        // Through reads, inhibited misses and all other writes go out single.
                        ibReq   <= 1'b1;
                        ibWr    <= bus.wr;
                        ibSize  <= bus.size;
                        ibAddr  <= bus.addr;
                        ibWdata <= next_wdata; // RQ2 RQ4
                        state   <= bus.wr ? ST_WRITE : ST_THRU; // RQ1 RQ3 RQ10
                    end
                end
                ST_THRU, ST_WRITE: if (ibAck) begin
                    ibReq     <= 1'b0;
                    bus.ack   <= 1'b1;
                    bus.rdata <= (state == ST_THRU) ? ibRdata : 32'h0; // RQ1
                    state     <= ST_IDLE;
                end
                ST_FILL: if (ibAck) begin
                    fillCnt  <= fillCnt + 2'h1;
                    fillWord <= fillWord + 2'h1;
                    ibAddr   <= {rAddr[31:fwc_pkg::IDX_LO], fillWord + 2'h1, 2'h0};
                    if (fillCnt == 2'(fwc_pkg::LINE_WORDS - 1)) begin
                        ibReq     <= 1'b0;
                        bus.ack   <= 1'b1;
                        bus.rdata <= ibRdata; // RQ5
                        state     <= ST_IDLE;
                    end
                end
                ST_PURGE: begin
                    bus.ack <= 1'b1; // RQ17
                    state   <= ST_IDLE;
                end
            endcase
        end
    end

    // Tag, valid and order arrays; no reset, so software must purge before enabling.
    always_ff @(posedge clk) begin
        if (take && bus.wr && isCtrl && bus.wdata[fwc_pkg::CTL_PURGE]) begin
            for (int e = 0; e < fwc_pkg::ENTRIES; e++) begin
                lruArr[e] <= '0; // RQ13
                for (int w = 0; w < fwc_pkg::WAYS; w++) begin
                    validArr[w][e] <= 1'b0; // RQ13
                end
            end
        end else if (doFill) begin
            // The new tag is valid at once; an aborted fill leaves a stale line.
            tagArr[victim][idx]   <= tag; // RQ12
            validArr[victim][idx] <= 1'b1; // RQ12
            lruArr[idx]           <= lruUpdate(lruNow, victim); // RQ6
        end else if (rdHit || wrHit) begin
            lruArr[idx] <= lruUpdate(lruNow, hitWay); // RQ6
        end else if (aaWrite) begin
            tagArr[aaWay][idx]   <= tag; // RQ22
            validArr[aaWay][idx] <= bus.addr[fwc_pkg::AA_VALID_BIT];
            lruArr[idx]          <= bus.wdata[fwc_pkg::AA_LRU_HI:fwc_pkg::AA_LRU_LO];
        end else if (state == ST_PURGE) begin
            for (int w = 0; w < fwc_pkg::WAYS; w++) begin
                if (rHit[w]) begin
                    validArr[w][rAddr[fwc_pkg::IDX_HI:fwc_pkg::IDX_LO]] <= 1'b0; // RQ16
                end
            end
        end
    end

    // Data array: fill words, write hits and direct window writes share one port.
    always_ff @(posedge clk) begin
        if (state == ST_FILL && ibAck) begin
            dataArr[{fillWay, rAddr[fwc_pkg::IDX_HI:fwc_pkg::IDX_LO], fillWord}] <= ibRdata;
        end else if (wrHit || dataWrite) begin
            for (int b = 0; b < 4; b++) begin
                if (byteEn[b]) begin
                    dataArr[wordIdx][8*b +: 8] <= next_wdata[8*b +: 8]; // RQ4 RQ18
                end
            end
        end
    end
endmodule

// file: logic/fwc_cpu_end.sv
// CPU-side requester that issues one cache bus access per command.
// Assumes the controller answers every request with one ack pulse.
`timescale 1ns/1ps
module fwc_cpu_end (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        rstn,
    // Cache bus toward the controller.
    fwc_if.cpu               bus,
    // Command port.
    input  wire logic        cmdValid,
    input  wire logic        cmdWr,
    input  wire logic        cmdInstr,
    input  wire logic        cmdAtomic,
    input  wire logic [1:0]  cmdSize,
    input  wire logic [31:0] cmdAddr,
    input  wire logic [31:0] cmdWdata,
    output logic             cmdReady,
    // Answer port.
    output logic             rspValid,
    output logic [31:0]      rspData
);
    logic [2:0]  area;
    logic [1:0]  next_size;
    logic [31:0] next_wdata;

    // Software duties that the controller leans on are enforced here.
    always_comb begin
        area       = cmdAddr[31:fwc_pkg::AREA_LO];
        next_size  = cmdSize;
        next_wdata = cmdWdata;
        if (cmdWr && area == fwc_pkg::AREA_PURGE) begin
            next_size = fwc_pkg::SZ_LONG; // RQ17
        end
        if (cmdWr && area == fwc_pkg::AREA_ADDRARR) begin
            next_wdata[fwc_pkg::AA_LRU_HI:fwc_pkg::AA_LRU_LO] = '0; // RQ22
        end
        // A purge always goes with the enable cleared, so prefetch cannot race it.
        if (cmdWr && cmdAddr == fwc_pkg::CTRL_ADDR && cmdWdata[fwc_pkg::CTL_PURGE]) begin
            next_wdata[fwc_pkg::CTL_EN] = 1'b0; // RQ15
        end
    end

    // One request in flight; ready drops from issue until the answer.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cmdReady   <= 1'b1;
            rspValid   <= 1'b0;
            rspData    <= 32'h0;
            bus.req    <= 1'b0;
            bus.wr     <= 1'b0;
            bus.instr  <= 1'b0;
            bus.atomic <= 1'b0;
            bus.size   <= fwc_pkg::SZ_LONG;
            bus.addr   <= 32'h0;
            bus.wdata  <= 32'h0;
        end else begin
            bus.req  <= 1'b0;
            rspValid <= 1'b0;
            if (cmdReady && cmdValid) begin
                cmdReady   <= 1'b0;
                bus.req    <= 1'b1;
                bus.wr     <= cmdWr;
                bus.instr  <= cmdInstr;
                bus.atomic <= cmdAtomic;
                bus.size   <= next_size;
                bus.addr   <= cmdAddr;
                bus.wdata  <= next_wdata;
            end else if (!cmdReady && bus.ack) begin
                cmdReady <= 1'b1;
                rspValid <= 1'b1;
                rspData  <= bus.rdata;
            end
        end
    end
endmodule

// file: tb/fwc_assertions.sv
// Concurrent checks on the cache bus and the internal bus of the cache controller.
// Assumes one clock for both buses and an active low asynchronous reset.
`timescale 1ns/1ps
module fwc_assertions (
    // Clock and reset.
    input logic        clk,
    input logic        rstn,
    // Cache bus.
    input logic        req,
    input logic        wr,
    input logic        atomic,
    input logic [1:0]  size,
    input logic [31:0] addr,
    input logic [31:0] wdata,
    input logic        ack,
    // Internal bus.
    input logic        ibReq,
    input logic        ibWr,
    input logic [31:0] ibAddr,
    input logic [31:0] ibWdata,
    input logic        ibAck
);
    // One domain, so one clock and one disable serve every property.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_ack_one_pulse: assert property (ack |=> !ack) else $error("ack held high");
    a_ctrl_fast: assert property (req && addr == fwc_pkg::CTRL_ADDR |=> ack && !ibReq)
        else $error("control access slow");
    a_purge_two_cycles: assert property (req && wr && addr[31:29] == fwc_pkg::AREA_PURGE
        |=> !ack ##1 ack) else $error("line purge timing");
    a_data_array_fast: assert property (req && addr[31:29] == fwc_pkg::AREA_DATAARR
        && addr[28:12] == 17'h0 |=> ack && !ibReq) else $error("data array slow");
    a_addr_array_fast: assert property (req && addr[31:29] == fwc_pkg::AREA_ADDRARR
        && addr[28:10] == 19'h0 |=> ack && !ibReq) else $error("address array slow");
    a_thru_read_out: assert property (req && !wr && addr[31:29] == fwc_pkg::AREA_THRU |=>
        ibReq && !ibWr && ibAddr[28:2] == $past(addr[28:2])) else $error("through read");
    a_thru_write_out: assert property (req && wr && addr[31:29] == fwc_pkg::AREA_THRU |=>
        ibReq && ibWr && ibWdata == $past(wdata)) else $error("through write");
    a_atomic_read_thru: assert property (req && atomic && !wr |=> ibReq && !ibWr)
        else $error("atomic read not external");
    a_atomic_top_set: assert property (req && wr && atomic && size == fwc_pkg::SZ_BYTE
        && addr[1:0] == 2'h0 |=> ibWr && ibWdata[31]) else $error("atomic bit clear");
    a_ib_request_hold: assert property (ibReq && !ibAck |=> ibReq && $stable(ibAddr)
        && $stable(ibWr)) else $error("internal request dropped");

    // Main scenarios reached.
    c_purge: cover property (req && wr && addr[31:29] == fwc_pkg::AREA_PURGE);
    c_atomic: cover property (req && wr && atomic);
    c_thru: cover property (req && addr[31:29] == fwc_pkg::AREA_THRU);
endmodule

// file: tb/four_way_cache_lru_purge_tb_top.sv
// Bench joining the requester and the cache controller, with a prompt memory model.
// Assumes command-port timing as handed over and memory data that depends on address only.
`timescale 1ns/1ps
module four_way_cache_lru_purge_tb_top;
    logic clk = 1'b0, rstn = 1'b0, cmdValid = 1'b0, cmdWr = 1'b0, cmdInstr = 1'b0;
    logic cmdAtomic = 1'b0, cmdReady, rspValid, ibReq, ibWr, ibAck = 1'b0, cacheEnabled;
    logic [1:0]  cmdSize = 2'h2, ibSize;
    logic [31:0] cmdAddr = 32'h0, cmdWdata = 32'h0, rspData, ibAddr, ibWdata;
    logic [31:0] ibRdata = 32'h0, rdCnt = 32'h0, lastWd = 32'h0, rdv, r0;
    int          error_cnt = 0, check_count = 0;
    localparam logic [31:0] A = 32'h00012340, B = 32'h00016340, C = 32'h0001A340;
    localparam logic [31:0] AW = fwc_pkg::ADDR_WIN_BASE | 32'h00000340, D = 32'h0001E340;
    localparam logic [31:0] TAGM = 32'h1FFFFC00, CA = fwc_pkg::CTRL_ADDR;

    fwc_if bus ();
    fwc_cache fwc_cache_i (.clk(clk), .rstn(rstn), .bus(bus), .ibReq(ibReq), .ibWr(ibWr),
        .ibSize(ibSize), .ibAddr(ibAddr), .ibWdata(ibWdata), .ibAck(ibAck),
        .ibRdata(ibRdata), .cacheEnabled(cacheEnabled));
    fwc_cpu_end fwc_cpu_end_i (.clk(clk), .rstn(rstn), .bus(bus), .cmdValid(cmdValid),
        .cmdWr(cmdWr), .cmdInstr(cmdInstr), .cmdAtomic(cmdAtomic), .cmdSize(cmdSize),
        .cmdAddr(cmdAddr), .cmdWdata(cmdWdata), .cmdReady(cmdReady), .rspValid(rspValid),
        .rspData(rspData));
    fwc_assertions fwc_assertions_i (.clk(clk), .rstn(rstn), .req(bus.req), .wr(bus.wr),
        .atomic(bus.atomic), .size(bus.size), .addr(bus.addr), .wdata(bus.wdata),
        .ack(bus.ack), .ibReq(ibReq), .ibWr(ibWr), .ibAddr(ibAddr), .ibWdata(ibWdata),
        .ibAck(ibAck));

    // Clock of 100 MHz.
    always #5 clk = ~clk;

    // Memory data ignores the area bits, so through and cached views agree.
    function automatic logic [31:0] memv(input logic [31:0] a);
        return (a & 32'h1FFFFFFC) ^ 32'h0A5A5A50;
    endfunction

    // Memory answers each word one cycle later; between answers the data lines toggle.
    always @(posedge clk) begin
        ibAck <= ibReq && !ibAck;
        ibRdata <= (ibReq && !ibAck) ? memv(ibAddr) : ~ibRdata;
        if (ibReq && !ibAck && !ibWr) rdCnt <= rdCnt + 32'h1;
        if (ibReq && !ibAck && ibWr) lastWd <= ibWdata;
    end

    // Compares one value and counts the outcome.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t mismatch got %h expected %h", $time, got, exp);
        end
    endtask

    // One command through the requester; called at a rising edge, result left in rdv.
    task automatic acc(input logic w, input logic at, input logic [1:0] sz,
                       input logic [31:0] a, input logic [31:0] d);
        int n;
        cmdValid <= 1'b1;
        cmdWr <= w;
        cmdAtomic <= at;
        cmdSize <= sz;
        cmdAddr <= a;
        cmdWdata <= d;
        @(posedge clk);
        cmdValid <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (rspValid !== 1'b1 && n < 60);
        if (n >= 60) chk(32'h0, 32'h1);
        rdv = rspData;
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // A hang is cut short well beyond the few hundred cycles the tests need.
    initial begin
        #100us;
        error_cnt++;
        print_verdict();
    end

    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        chk(cacheEnabled, 32'h0);
        acc(1'b1, 1'b0, 2'h2, CA, 32'h00000011);
        acc(1'b0, 1'b0, 2'h2, CA, 32'h0);
        chk(rdv & 32'hFF, 32'h0);
        acc(1'b1, 1'b0, 2'h2, CA, 32'h00000001);
        chk(cacheEnabled, 32'h1);
        $display("test purge and enable done");
        // Fill after purge goes to way 3, then a hit needs no memory access.
        r0 = rdCnt;
        acc(1'b0, 1'b0, 2'h2, A, 32'h0);
        chk(rdv, memv(A));
        chk(rdCnt - r0, 32'h4);
        acc(1'b0, 1'b0, 2'h2, A, 32'h0);
        chk(rdCnt - r0, 32'h4);
        acc(1'b1, 1'b0, 2'h2, CA, 32'h000000C1);
        acc(1'b0, 1'b0, 2'h2, AW, 32'h0);
        chk(rdv, (A & TAGM) | 32'h000000B4);
        // Order bits 0x0B pick way 2 as victim; its update gives 0x1E.
        acc(1'b0, 1'b0, 2'h2, B, 32'h0);
        acc(1'b1, 1'b0, 2'h2, CA, 32'h00000081);
        acc(1'b0, 1'b0, 2'h2, AW, 32'h0);
        chk(rdv, (B & TAGM) | 32'h000001E4);
        $display("test replacement order done");
        // Ways sit in separate 1-kbyte blocks of the data window.
        acc(1'b0, 1'b0, 2'h2, 32'hC0000F40, 32'h0);
        chk(rdv, memv(A));
        acc(1'b1, 1'b0, 2'h2, 32'hC0000340, 32'hCAFE0001);
        acc(1'b1, 1'b0, 2'h0, 32'hC0000341, 32'h00770000);
        acc(1'b0, 1'b0, 2'h2, 32'hC0000340, 32'h0);
        chk(rdv, 32'hCA770001);
        acc(1'b0, 1'b0, 2'h2, 32'hC0000F40, 32'h0);
        chk(rdv, memv(A));
        $display("test data array done");
        // Through accesses touch one word and never the arrays.
        r0 = rdCnt;
        acc(1'b0, 1'b0, 2'h2, A | 32'h20000000, 32'h0);
        chk(rdv, memv(A));
        chk(rdCnt - r0, 32'h1);
        acc(1'b1, 1'b0, 2'h2, A | 32'h20000000, 32'h11223344);
        chk(lastWd, 32'h11223344);
        acc(1'b0, 1'b0, 2'h2, A, 32'h0);
        chk(rdv, memv(A));
        chk(rdCnt - r0, 32'h1);
        $display("test through access done");
        // Atomic read goes out despite a hit; write-back sets the top bit everywhere.
        acc(1'b0, 1'b1, 2'h0, A, 32'h0);
        chk(rdCnt - r0, 32'h2);
        acc(1'b1, 1'b1, 2'h0, A, 32'h12000000);
        chk(lastWd & 32'hFF000000, 32'h92000000);
        acc(1'b0, 1'b0, 2'h2, A, 32'h0);
        chk(rdv & 32'hFF000000, 32'h92000000);
        chk(rdCnt - r0, 32'h2);
        $display("test atomic done");
        // A line purge forces a fresh fill; an inhibited miss reads one word only.
        acc(1'b1, 1'b0, 2'h2, A + fwc_pkg::PURGE_OFFSET, 32'h0);
        r0 = rdCnt;
        acc(1'b0, 1'b0, 2'h2, A, 32'h0);
        chk(rdCnt - r0, 32'h4);
        chk(rdv, memv(A));
        acc(1'b1, 1'b0, 2'h2, CA, 32'h00000005);
        acc(1'b0, 1'b0, 2'h2, C, 32'h0);
        chk(rdv, memv(C));
        chk(rdCnt - r0, 32'h5);
        $display("test purge line and inhibit done");
        // Order bits 0x39 pick way 0 in four-way mode but way 2 in two-way mode.
        acc(1'b1, 1'b0, 2'h2, CA, 32'h00000089);
        acc(1'b0, 1'b0, 2'h2, D, 32'h0);
        acc(1'b0, 1'b0, 2'h2, AW, 32'h0);
        chk(rdv, (D & TAGM) | 32'h000003C4);
        acc(1'b1, 1'b0, 2'h2, AW, 32'h000003F0);
        acc(1'b0, 1'b0, 2'h2, AW, 32'h0);
        chk(rdv, 32'h0);
        // An instruction miss under the instruction inhibit reads one word only.
        acc(1'b1, 1'b0, 2'h2, CA, 32'h00000003);
        cmdInstr <= 1'b1;
        r0 = rdCnt;
        acc(1'b0, 1'b0, 2'h2, D, 32'h0);
        chk(rdCnt - r0, 32'h1);
        $display("test two-way and instruction inhibit done");
        print_verdict();
    end
endmodule
